// File: logic/wmp_pkg.sv
// Package for the waveform memory playlist register slice
package wmp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int MEM_AW = 14;
	localparam int WORD_W = 12;
	localparam int CNT_W  = 5;
	localparam logic [ADDR_W-1:0] OFS_READ_PTR  = 8'h0B;
	localparam logic [ADDR_W-1:0] OFS_READ_WORD = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_WAVE_CNT  = 8'h0D;
	localparam logic [ADDR_W-1:0] OFS_CLIP0_END = 8'h0E;
	localparam logic [ADDR_W-1:0] OFS_CLIP1_END = 8'h0F;
	localparam int STORED_LSB = 0;
	localparam int PLAY_LSB   = 8;
	localparam logic [WORD_W-1:0] RST_READ_WORD = 12'h000;
	localparam logic [CNT_W-1:0]  RST_COUNT     = 5'h00;
	localparam logic [MEM_AW-1:0] RST_END_PTR   = 14'h0000;
	localparam logic [MEM_AW-1:0] RST_START     = 14'h0000;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} wmp_req_t;

	typedef struct packed {
		logic              en;
		logic [MEM_AW-1:0] addr;
	} wmp_mem_req_t;

	typedef enum logic [1:0] {
		PS_IDLE  = 2'b00,
		PS_START = 2'b01,
		PS_PLAY  = 2'b10
	} wmp_play_t;
endpackage : wmp_pkg

// File: logic/wmp_regs.sv
// Register slice: readback word, waveform counts, clip end pointers
//
// Behaviour
// - Writing the readback pointer fetches that memory word into readback.
// - Readback word is 12 bits, upper bits zero, resets zero, read only.
// - Playback plays exactly play-count clips in playlist order, then stops.
// - Clip 0 and 1 end pointers are 14-bit read/write, reset zero.
`timescale 1ns/1ns
module wmp_regs (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire wmp_pkg::wmp_req_t             busReq,
	output logic [wmp_pkg::DATA_W-1:0]         busRdata,
	output logic                               busRvalid,
	output wmp_pkg::wmp_mem_req_t              memReq,
	input  wire logic [wmp_pkg::WORD_W-1:0]    memRdata,
	input  wire logic                          playStart,
	input  wire logic                          clipDone,
	output logic                               playing,
	output logic [wmp_pkg::CNT_W-1:0]          clipIndex,
	output logic [wmp_pkg::MEM_AW-1:0]         clipStart,
	output logic [wmp_pkg::MEM_AW-1:0]         clipEnd,
	output logic [wmp_pkg::CNT_W-1:0]          storedCount
);
	import wmp_pkg::*;
	logic [WORD_W-1:0] readWord_r;
	logic              fetch_r;
	logic [CNT_W-1:0]  playCnt_r;
	logic [MEM_AW-1:0] clip0End_r;
	logic [MEM_AW-1:0] clip1End_r;
	logic              seqPlaying;
	logic [CNT_W-1:0]  seqIndex;
	logic              wrPtr;

	assign wrPtr = busReq.wr && busReq.addr == OFS_READ_PTR;

	// Memory answers one cycle after the request; readback latches it one cycle later
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			memReq     <= '0;
			fetch_r    <= 1'b0;
			readWord_r <= RST_READ_WORD;
		end else begin
			memReq.en <= wrPtr;
			if (wrPtr) begin
				memReq.addr <= busReq.wdata[MEM_AW-1:0];
			end
			fetch_r <= memReq.en;
			if (fetch_r) begin
				readWord_r <= memRdata;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			playCnt_r   <= RST_COUNT;
			storedCount <= RST_COUNT;
			clip0End_r  <= RST_END_PTR;
			clip1End_r  <= RST_END_PTR;
		end else if (busReq.wr) begin
			case (busReq.addr)
				OFS_WAVE_CNT: begin
					playCnt_r   <= busReq.wdata[PLAY_LSB +: CNT_W];
					storedCount <= busReq.wdata[STORED_LSB +: CNT_W];
				end
				OFS_CLIP0_END: clip0End_r <= busReq.wdata[MEM_AW-1:0];
				OFS_CLIP1_END: clip1End_r <= busReq.wdata[MEM_AW-1:0];
				default: begin
				end
			endcase
		end
	end

	// Reads of write-only or unmapped offsets return zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busRdata  <= '0;
			busRvalid <= 1'b0;
		end else begin
			busRvalid <= busReq.rd;
			if (busReq.rd) begin
				case (busReq.addr)
					OFS_READ_WORD: busRdata <= {4'h0, readWord_r};
					OFS_WAVE_CNT:  busRdata <= {3'h0, playCnt_r,
						3'h0, storedCount};
					OFS_CLIP0_END: busRdata <= {2'h0, clip0End_r};
					OFS_CLIP1_END: busRdata <= {2'h0, clip1End_r};
					default:       busRdata <= '0;
				endcase
			end
		end
	end

	wmp_sequencer #(
		.CW (CNT_W)
	) u_seq (
		.clk       (clk),
		.resetn    (resetn),
		.start     (playStart),
		.playCount (playCnt_r),
		.clipDone  (clipDone),
		.playing   (seqPlaying),
		.clipIndex (seqIndex)
	);

	// Only clips 0 and 1 are held here; later clips report zero bounds
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			playing   <= 1'b0;
			clipIndex <= '0;
			clipStart <= RST_START;
			clipEnd   <= RST_END_PTR;
		end else begin
			playing   <= seqPlaying;
			clipIndex <= seqIndex;
			case (seqIndex)
				CNT_W'(0): begin
					clipStart <= RST_START;
					clipEnd   <= clip0End_r;
				end
				CNT_W'(1): begin
					clipStart <= clip0End_r + MEM_AW'(1);
					clipEnd   <= clip1End_r;
				end
				default: begin
					clipStart <= RST_START;
					clipEnd   <= RST_END_PTR;
				end
			endcase
		end
	end
endmodule : wmp_regs

// File: logic/wmp_sequencer.sv
// Playlist sequencer: plays the requested number of clips in order
`timescale 1ns/1ns
module wmp_sequencer #(
	parameter int CW = 5
) (
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    start,
	input  wire logic [CW-1:0]           playCount,
	input  wire logic                    clipDone,
	output logic                         playing,
	output logic [CW-1:0]                clipIndex
);
	import wmp_pkg::*;
	wmp_play_t   state_r;
	logic [CW-1:0] left_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r   <= PS_IDLE;
			left_r    <= '0;
			clipIndex <= '0;
			playing   <= 1'b0;
		end else begin
			case (state_r)
				PS_IDLE: begin
					if (start && playCount != '0) begin
						state_r   <= PS_START;
						left_r    <= playCount;
						clipIndex <= '0;
					end
				end
				PS_START: begin
					playing <= 1'b1;
					state_r <= PS_PLAY;
				end
				PS_PLAY: begin
					if (clipDone) begin
						if (left_r == CW'(1)) begin
							playing <= 1'b0;
							state_r <= PS_IDLE;
						end else begin
							left_r    <= left_r - CW'(1);
							clipIndex <= clipIndex + CW'(1);
						end
					end
				end
				default: begin
					state_r <= PS_IDLE;
					playing <= 1'b0;
				end
			endcase
		end
	end
endmodule : wmp_sequencer

// File: sim/waveform_memory_playlist_regs_tb.sv
// Bench for the register slice
`timescale 1ns/1ns
module waveform_memory_playlist_regs_tb;
	import wmp_pkg::*;
	logic clk = 0, resetn = 0, playStart = 0, clipDone = 0, busRvalid;
	logic playing;
	wmp_req_t req = '0;
	wmp_mem_req_t memReq;
	logic [15:0] busRdata;
	logic [11:0] memRdata;
	logic [4:0] clipIndex, storedCount;
	logic [13:0] clipStart, clipEnd;
	int expStart, expEnd;
	int numErrors = 0, testsRun = 0, m [16] = '{default: 0}, a;
	always #5 clk = ~clk;
	wmp_regs wmp_regs_i (.clk, .resetn, .busReq(req), .busRdata, .busRvalid,
		.memReq, .memRdata, .playStart, .clipDone, .playing, .clipIndex,
		.clipStart, .clipEnd, .storedCount);
	wmp_mem_model wmp_mem_model_i (.clk, .memReq, .memRdata);
	task automatic chk(logic [15:0] s, logic [15:0] e);
		testsRun++;
		if (s !== e) begin
			numErrors++;
			$display("ERROR %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic endOfTest;
		$display("checks %0d errors %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : endOfTest
	task automatic wr(logic [7:0] ad, logic [15:0] d);
		@(negedge clk);
		req = '{1'b1, 1'b0, ad, d};
		@(negedge clk);
		req.wr = 0;
		if (ad == 8'h0D)
			m[13] = d & 16'h1F1F;
		if (ad > 8'h0D)
			m[ad[3:0]] = d & 16'h3FFF;
	endtask : wr
	task automatic rd(logic [7:0] ad);
		@(negedge clk);
		req = '{1'b0, 1'b1, ad, 16'h0};
		for (int i = 0; i < 4 && busRvalid !== 1'b1; i++) begin
			@(negedge clk);
			req.rd = 0;
		end
		if (busRvalid !== 1'b1) begin
			numErrors++;
			endOfTest();
		end
	endtask : rd
	initial begin
		a = $urandom(32'h1BC9);
		repeat (20) @(negedge clk);
		resetn = 1;
		for (int r = 12; r < 16; r++) begin
			rd(8'(r));
			chk(busRdata, 16'h0000);
			wr(8'(r), 16'($urandom));
			rd(8'(r));
			chk(busRdata, 16'(m[r]));
		end
		$display("registers done");
		repeat (3) begin
			a = $urandom & 32'h3FFF;
			wr(8'h0B, 16'(a));
			repeat (2) @(negedge clk);
			rd(8'h0C);
			chk(busRdata, 16'(a[11:0] ^ 12'hA5C));
		end
		$display("readback done");
		wr(8'h0D, 16'h0305);
		chk(16'(storedCount), 16'h0005);
		@(negedge clk);
		playStart = 1;
		@(negedge clk);
		playStart = 0;
		for (int k = 0; k < 3; k++) begin
			repeat (4) @(negedge clk);
			chk({15'h0, playing}, 16'h0001);
			chk(16'(clipIndex), 16'(k));
			expStart = (k == 1) ? ((m[14] + 1) & 16'h3FFF) : 0;
			expEnd = (k == 0) ? m[14] : ((k == 1) ? m[15] : 0);
			chk(16'(clipStart), 16'(expStart));
			chk(16'(clipEnd), 16'(expEnd));
			clipDone = 1;
			@(negedge clk);
			clipDone = 0;
		end
		repeat (3) @(negedge clk);
		chk({15'h0, playing}, 16'h0000);
		$display("playback done");
		endOfTest();
	end
endmodule : waveform_memory_playlist_regs_tb

// File: sim/wmp_mem_model.sv
// Waveform memory model
`timescale 1ns/1ns
module wmp_mem_model (
	input wire logic clk,
	input wire wmp_pkg::wmp_mem_req_t memReq,
	output logic [11:0] memRdata
);
	initial memRdata = 12'h5A5;
	// Stale data inverts, so a late sample is seen
	always @(posedge clk) begin
		if (memReq.en)
			memRdata <= memReq.addr[11:0] ^ 12'hA5C;
		else
			memRdata <= ~memRdata;
	end
endmodule : wmp_mem_model

// File: sim/wmp_regs_monitor.sv
// Port checker for the register slice
`timescale 1ns/1ns
module wmp_regs_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire wmp_pkg::wmp_req_t busReq,
	input wire logic [15:0] busRdata,
	input wire logic busRvalid,
	input wire wmp_pkg::wmp_mem_req_t memReq,
	input wire logic playStart,
	input wire logic playing
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_RD: assert property (busReq.rd |=> busRvalid)
		else $error("no read answer");
	AST_FETCH: assert property (busReq.wr && busReq.addr == 8'h0B |=>
		memReq.en && memReq.addr == $past(busReq.wdata[13:0]))
		else $error("bad fetch");
	AST_WORD: assert property (busReq.rd && busReq.addr == 8'h0C |=>
		busRdata[15:12] == 4'h0) else $error("word too wide");
	AST_START: assert property ($rose(playing) |-> $past(playStart, 3))
		else $error("bad start");
	AST_END: assert property (busReq.wr && busReq.addr == 8'h0E ##2
		busReq.rd && busReq.addr == 8'h0E |=>
		busRdata == {2'b00, $past(busReq.wdata[13:0], 3)})
		else $error("end pointer lost");
	cover property (memReq.en);
	cover property ($fell(playing));
	cover property (busRvalid && busRdata != 16'h0000);
endmodule : wmp_regs_monitor
bind wmp_regs wmp_regs_monitor wmp_regs_monitor_i (.clk, .resetn,
	.busReq, .busRdata, .busRvalid, .memReq, .playStart, .playing);
